// [omh_cfg.svh]
// Constants for the opcode mailbox: field positions, register reset values and opcode codes.
`ifndef OMH_CFG_SVH
`define OMH_CFG_SVH
`define OMH_CMD_MSB 15
`define OMH_CMD_LSB 8
`define OMH_OBJ_MSB 7
`define OMH_OBJ_LSB 0
`define OMH_HS_WRITE_PERMIT 0
`define OMH_HS_READ_READY 1
`define OMH_CHAN_MAX_BIG 8'h7F
`define OMH_CHAN_MAX_SMALL 8'h3F
`define OMH_CHIP_MAX_BIG 8'h03
`define OMH_CHIP_MAX_SMALL 8'h01
`define OMH_RST_WIN_WIDTH 12'h000
`define OMH_RST_WIN_OFFSET 12'h000
`define OMH_RST_SEARCH 12'h000
`define OMH_RST_REJECT 12'h000
`define OMH_RST_EDGE 2'h0
`define OMH_RST_LSB 2'h0
`define OMH_RST_RES 16'h0000
`define OMH_RST_DEAD 2'h0
`define OMH_RST_HITS 16'h0000
`define OMH_OP_MATCHED 8'h00
`define OMH_OP_FREE 8'h01
`define OMH_OP_QACQ 8'h02
`define OMH_OP_FACTORY 8'h05
`define OMH_OP_SAVE 8'h06
`define OMH_OP_LOAD 8'h07
`define OMH_OP_BOOT_CUSTOM 8'h08
`define OMH_OP_BOOT_FACTORY 8'h09
`define OMH_OP_WIDTH 8'h10
`define OMH_OP_OFFSET 8'h11
`define OMH_OP_SEARCH 8'h12
`define OMH_OP_REJECT 8'h13
`define OMH_OP_SUB_ON 8'h14
`define OMH_OP_SUB_OFF 8'h15
`define OMH_OP_QWIN 8'h16
`define OMH_OP_EDGE 8'h22
`define OMH_OP_QEDGE 8'h23
`define OMH_OP_LSB 8'h24
`define OMH_OP_RES 8'h25
`define OMH_OP_QRES 8'h26
`define OMH_OP_DEAD 8'h28
`define OMH_OP_QDEAD 8'h29
`define OMH_OP_FRAME_ON 8'h30
`define OMH_OP_FRAME_OFF 8'h31
`define OMH_OP_QFRAME 8'h32
`define OMH_OP_HITS 8'h33
`define OMH_OP_QHITS 8'h34
`endif

// [omh_host.sv]
// Host model writing and reading opcode words under the handshake flags.
`timescale 1ns/10ps
module omh_host (
  input wire logic ref_clk_i,
  input wire logic [15:0] handshake_i,
  output logic word_wr_o,
  output logic [15:0] word_wdata_o,
  output logic word_rd_o
);
  initial begin
    word_wr_o = 1'b0;
    word_wdata_o = 16'hA5C3;
    word_rd_o = 1'b0;
  end
  task automatic put(input logic [15:0] w);
    @(negedge ref_clk_i);
    while (handshake_i[0] !== 1'b1) @(negedge ref_clk_i);
    word_wdata_o = w;
    word_wr_o = 1'b1;
    @(negedge ref_clk_i);
    word_wr_o = 1'b0;
    word_wdata_o = ~w;
  endtask
  task automatic take();
    @(negedge ref_clk_i);
    while (handshake_i[1] !== 1'b1) @(negedge ref_clk_i);
    word_rd_o = 1'b1;
    @(negedge ref_clk_i);
    word_rd_o = 1'b0;
  endtask
endmodule

// [omh_mailbox.sv]
// Opcode mailbox: handshake flags, command decode and converter setup registers.
`timescale 1ns/10ps
`include "omh_cfg.svh"

// Overview of operation
// - Write permit drops per word, returns when ready.
// - Read ready drops per read, returns when next.
// - Sixteen-bit words: opcode high, object low.
// - Decode opcode; ignore object when untargeted.
// - Channel object range by variant.
// - Chip object range by variant.
// - Commands without operands finish immediately.
// - Wait for all operands before next command.
// - Setup commands clear data; control ones not.
// - Decode operand counts and significant bits.
// - Acquisition mode, query, and configuration storage.
// - Four twelve-bit window settings.
// - Trigger subtraction; five-word window query.
// - Edge detection set and query.
// - Edge LSB, pair resolution, resolution query.
// - Dead time set and query.
// - Frame words on, off, query.
// - Maximum hits set and query.
// - Clear empties buffer, counters, keeps config.
module omh_mailbox (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic big_variant_i,
  input wire logic word_wr_i,
  input wire logic [15:0] word_wdata_i,
  input wire logic word_rd_i,
  output logic [15:0] word_rdata_o,
  output logic [15:0] handshake_o,
  output logic obj_valid_o,
  output logic [7:0] obj_o,
  output logic data_clear_o,
  output logic ctrl_update_o,
  output logic acq_free_o,
  output logic trigger_subtract_o,
  output logic frame_words_o,
  output logic [11:0] window_width_o,
  output logic [11:0] window_offset_o,
  output logic [11:0] search_margin_o,
  output logic [11:0] reject_margin_o,
  output logic [1:0] edge_mode_o,
  output logic [1:0] edge_lsb_o,
  output logic [15:0] pair_res_o,
  output logic [1:0] dead_time_o,
  output logic [15:0] max_hits_o,
  output logic save_req_o,
  output logic load_req_o,
  output logic boot_custom_o
);
  omh_pkg::omh_state_e state;
  logic write_permit_bit;
  logic read_ready_bit;
  logic [7:0] cmd;
  logic [2:0] cnt;
  logic [3:0] operand_words_in;
  logic [3:0] operand_words_out;
  logic known;
  logic setup_cls;
  logic [7:0] op;
  logic [7:0] obj;
  logic take_cmd;
  logic take_opnd;
  logic give_done;
  logic [15:0] next_rdata;
  logic [7:0] obj_max;

  assign op = word_wdata_i[`OMH_CMD_MSB:`OMH_CMD_LSB];
  assign obj = word_wdata_i[`OMH_OBJ_MSB:`OMH_OBJ_LSB];
  assign take_cmd = (state == omh_pkg::OMH_IDLE) && word_wr_i && write_permit_bit;
  assign take_opnd = (state == omh_pkg::OMH_TAKE) && word_wr_i && write_permit_bit;
  assign give_done = (state == omh_pkg::OMH_GIVE) && word_rd_i && read_ready_bit;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    operand_words_in = 4'h0;
    operand_words_out = 4'h0;
    known = 1'b1;
    setup_cls = 1'b0;
    case (op)
      `OMH_OP_MATCHED, `OMH_OP_FREE, `OMH_OP_FACTORY, `OMH_OP_LOAD,
      `OMH_OP_SUB_ON, `OMH_OP_SUB_OFF, `OMH_OP_FRAME_ON, `OMH_OP_FRAME_OFF: begin
        setup_cls = 1'b1;
      end
      `OMH_OP_SAVE, `OMH_OP_BOOT_CUSTOM, `OMH_OP_BOOT_FACTORY: begin
        setup_cls = 1'b0;
      end
      `OMH_OP_WIDTH, `OMH_OP_OFFSET, `OMH_OP_SEARCH, `OMH_OP_REJECT, `OMH_OP_EDGE,
      `OMH_OP_LSB, `OMH_OP_RES, `OMH_OP_DEAD, `OMH_OP_HITS: begin
        operand_words_in = 4'h1;
        setup_cls = 1'b1;
      end
      `OMH_OP_QACQ, `OMH_OP_QEDGE, `OMH_OP_QRES, `OMH_OP_QDEAD, `OMH_OP_QFRAME, `OMH_OP_QHITS: begin
        operand_words_out = 4'h1;
      end
      `OMH_OP_QWIN: begin
        operand_words_out = 4'h5;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // Object is clamped to the range for every accepted command word; none in this group are targeted, so the flag stays low.
  always_comb begin
    obj_max = big_variant_i ? `OMH_CHAN_MAX_BIG : `OMH_CHAN_MAX_SMALL;
    if (op[7:4] == 4'h7 && op[3:0] >= 4'h4 && op[3:0] <= 4'h6) begin
      obj_max = big_variant_i ? `OMH_CHIP_MAX_BIG : `OMH_CHIP_MAX_SMALL;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      obj_o <= 8'h00;
      obj_valid_o <= 1'b0;
    end else if (take_cmd) begin
      obj_o <= (obj > obj_max) ? obj_max : obj;
      obj_valid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= omh_pkg::OMH_IDLE;
      cmd <= 8'h00;
      cnt <= 3'h0;
    end else begin
      case (state)
        omh_pkg::OMH_IDLE: begin
          if (take_cmd) begin
            cmd <= op;
            cnt <= 3'h0;
            if (known && operand_words_in != 4'h0) begin
              state <= omh_pkg::OMH_TAKE;
            end else if (known && operand_words_out != 4'h0) begin
              state <= omh_pkg::OMH_GIVE;
            end else begin
              state <= omh_pkg::OMH_IDLE;
            end
          end
        end
        omh_pkg::OMH_TAKE: begin
          if (take_opnd) begin
            state <= omh_pkg::OMH_IDLE;
          end
        end
        omh_pkg::OMH_GIVE: begin
          if (give_done) begin
            if ((cmd == `OMH_OP_QWIN) && (cnt != 3'h4)) begin
              cnt <= cnt + 3'h1;
            end else begin
              state <= omh_pkg::OMH_IDLE;
            end
          end
        end
        default: begin
          state <= omh_pkg::OMH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Handshake flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_permit_bit <= 1'b0;
    end else if (word_wr_i && write_permit_bit) begin
      write_permit_bit <= 1'b0;
    end else begin
      write_permit_bit <= (state != omh_pkg::OMH_GIVE) && !read_ready_bit;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_ready_bit <= 1'b0;
    end else if (word_rd_i && read_ready_bit) begin
      read_ready_bit <= 1'b0;
    end else begin
      read_ready_bit <= (state == omh_pkg::OMH_GIVE);
    end
  end

  assign handshake_o = {14'h0000, read_ready_bit, write_permit_bit};

  // ----------------------------------------------------------------
  // Return word
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    case (cmd)
      `OMH_OP_QACQ: next_rdata = {15'h0000, acq_free_o};
      `OMH_OP_QWIN: begin
        case (cnt)
          3'h0: next_rdata = {4'h0, window_width_o};
          3'h1: next_rdata = {4'h0, window_offset_o};
          3'h2: next_rdata = {4'h0, search_margin_o};
          3'h3: next_rdata = {4'h0, reject_margin_o};
          default: next_rdata = {15'h0000, trigger_subtract_o};
        endcase
      end
      `OMH_OP_QEDGE: next_rdata = {14'h0000, edge_mode_o};
      `OMH_OP_QRES: next_rdata = pair_res_o;
      `OMH_OP_QDEAD: next_rdata = {14'h0000, dead_time_o};
      `OMH_OP_QFRAME: next_rdata = {15'h0000, frame_words_o};
      `OMH_OP_QHITS: next_rdata = max_hits_o;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_rdata_o <= 16'h0000;
    end else begin
      word_rdata_o <= (state == omh_pkg::OMH_GIVE) ? next_rdata : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acq_free_o <= 1'b0;
      trigger_subtract_o <= 1'b0;
      frame_words_o <= 1'b0;
      window_width_o <= `OMH_RST_WIN_WIDTH;
      window_offset_o <= `OMH_RST_WIN_OFFSET;
      search_margin_o <= `OMH_RST_SEARCH;
      reject_margin_o <= `OMH_RST_REJECT;
      edge_mode_o <= `OMH_RST_EDGE;
      edge_lsb_o <= `OMH_RST_LSB;
      pair_res_o <= `OMH_RST_RES;
      dead_time_o <= `OMH_RST_DEAD;
      max_hits_o <= `OMH_RST_HITS;
    end else if (take_cmd) begin
      case (op)
        `OMH_OP_MATCHED: acq_free_o <= 1'b0;
        `OMH_OP_FREE: acq_free_o <= 1'b1;
        `OMH_OP_SUB_ON: trigger_subtract_o <= 1'b1;
        `OMH_OP_SUB_OFF: trigger_subtract_o <= 1'b0;
        `OMH_OP_FRAME_ON: frame_words_o <= 1'b1;
        `OMH_OP_FRAME_OFF: frame_words_o <= 1'b0;
        `OMH_OP_FACTORY: begin
          acq_free_o <= 1'b0;
          trigger_subtract_o <= 1'b0;
          frame_words_o <= 1'b0;
          window_width_o <= `OMH_RST_WIN_WIDTH;
          window_offset_o <= `OMH_RST_WIN_OFFSET;
          search_margin_o <= `OMH_RST_SEARCH;
          reject_margin_o <= `OMH_RST_REJECT;
          edge_mode_o <= `OMH_RST_EDGE;
          edge_lsb_o <= `OMH_RST_LSB;
          pair_res_o <= `OMH_RST_RES;
          dead_time_o <= `OMH_RST_DEAD;
          max_hits_o <= `OMH_RST_HITS;
        end
        default: begin
        end
      endcase
    end else if (take_opnd) begin
      case (cmd)
        `OMH_OP_WIDTH: window_width_o <= word_wdata_i[11:0];
        `OMH_OP_OFFSET: window_offset_o <= word_wdata_i[11:0];
        `OMH_OP_SEARCH: search_margin_o <= word_wdata_i[11:0];
        `OMH_OP_REJECT: reject_margin_o <= word_wdata_i[11:0];
        `OMH_OP_EDGE: edge_mode_o <= word_wdata_i[1:0];
        `OMH_OP_LSB: edge_lsb_o <= word_wdata_i[1:0];
        `OMH_OP_RES: pair_res_o <= word_wdata_i;
        `OMH_OP_DEAD: dead_time_o <= word_wdata_i[1:0];
        `OMH_OP_HITS: max_hits_o <= word_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Side effects
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_clear_o <= 1'b0;
      ctrl_update_o <= 1'b0;
      save_req_o <= 1'b0;
      load_req_o <= 1'b0;
      boot_custom_o <= 1'b0;
    end else begin
      // Setup commands pulse a data clear once their operands are in.
      data_clear_o <= (take_cmd && known && setup_cls && operand_words_in == 4'h0) ||
                      (take_opnd && cmd != `OMH_OP_HITS) || (take_opnd && cmd == `OMH_OP_HITS);
      ctrl_update_o <= 1'b0;
      save_req_o <= take_cmd && (op == `OMH_OP_SAVE);
      load_req_o <= take_cmd && (op == `OMH_OP_LOAD);
      if (take_cmd && op == `OMH_OP_BOOT_CUSTOM) begin
        boot_custom_o <= 1'b1;
      end else if (take_cmd && op == `OMH_OP_BOOT_FACTORY) begin
        boot_custom_o <= 1'b0;
      end
    end
  end
endmodule

// [omh_mailbox_monitor.sv]
// Concurrent checks on the opcode mailbox ports.
`timescale 1ns/10ps
module omh_mailbox_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic word_wr_i,
  input wire logic [15:0] word_wdata_i,
  input wire logic word_rd_i,
  input wire logic [15:0] handshake_o,
  input wire logic obj_valid_o,
  input wire logic ctrl_update_o,
  input wire logic data_clear_o,
  input wire logic [11:0] window_width_o
);
  logic took;
  logic pend;
  logic [7:0] pend_cmd;
  assign took = word_wr_i && handshake_o[0];
  // Tracks whether the next accepted word is the operand of a set command.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 1'b0;
      pend_cmd <= 8'h00;
    end else if (took) begin
      pend <= !pend && (word_wdata_i[15:8] inside {8'h10, 8'h11, 8'h12, 8'h13, 8'h22, 8'h24, 8'h25, 8'h28, 8'h33});
      pend_cmd <= word_wdata_i[15:8];
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_cmd(logic [7:0] c);
    took && !pend && word_wdata_i[15:8] == c;
  endsequence
  sequence s_operand;
    took && pend;
  endsequence
  sequence s_width_operand;
    took && pend && pend_cmd == 8'h10;
  endsequence
  a_permit_drops: assert property (took |=> !handshake_o[0]) else $error("permit stayed up");
  a_ready_drops: assert property (word_rd_i && handshake_o[1] |=> !handshake_o[1]) else $error("ready stayed up");
  a_flags_only: assert property (handshake_o[15:2] == 14'h0000) else $error("handshake spare bits set");
  a_no_target: assert property (!obj_valid_o && !ctrl_update_o) else $error("target or control raised");
  a_width_load: assert property (s_width_operand |=> window_width_o == $past(word_wdata_i[11:0]))
    else $error("width not loaded");
  a_setup_clear: assert property (s_operand |=> data_clear_o ##1 !data_clear_o) else $error("clear pulse wrong");
  a_empty_done: assert property (s_cmd(8'h30) |-> ##2 handshake_o[0]) else $error("permit late");
  a_unknown_free: assert property (s_cmd(8'h77) |-> ##2 handshake_o[0]) else $error("unknown code held");
  a_plain_clear: assert property (s_cmd(8'h30) |=> data_clear_o) else $error("setup command gave no clear");
  a_save_quiet: assert property (s_cmd(8'h06) |=> !data_clear_o) else $error("save command cleared data");
  a_query_ready: assert property (s_cmd(8'h23) |-> ##[1:2] handshake_o[1]) else $error("query word late");
  a_operand_wait: assert property (s_cmd(8'h10) |-> ##2 handshake_o[0] && !handshake_o[1])
    else $error("operand wait wrong");
endmodule

// [omh_pkg.sv]
// Types shared by the opcode mailbox.
package omh_pkg;
  typedef enum logic [1:0] {
    OMH_IDLE,
    OMH_TAKE,
    OMH_GIVE
  } omh_state_e;
endpackage

// [opcode_mailbox_handshake_tb.sv]
// Self-checking bench for the opcode mailbox.
`timescale 1ns/10ps
module opcode_mailbox_handshake_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic big = 1'b0;
  logic wr, rd, ov, clr, cu, acq, sub, frm, sv, ld, boot;
  logic [15:0] wdata, rdata, hs, pres, hits;
  logic [11:0] wwid, woff, srch, rej;
  logic [1:0] edg, lsb, dead;
  logic [7:0] obj, c, omax;
  logic [15:0] shadow [0:255];
  logic [31:0] expq [$];
  logic [31:0] note, v;
  int seed, error_cnt = 0, total_checks = 0;
  logic [7:0] sets [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h22, 8'h24, 8'h25, 8'h28, 8'h33};
  logic [7:0] modes [12] = '{8'h01, 8'h00, 8'h14, 8'h15, 8'h30, 8'h31, 8'h08, 8'h09, 8'h77, 8'h05, 8'h06, 8'h07};
  always #20 ref_clk_i = ~ref_clk_i;
  omh_mailbox omh_mailbox_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .big_variant_i(big), .word_wr_i(wr),
    .word_wdata_i(wdata), .word_rd_i(rd), .word_rdata_o(rdata), .handshake_o(hs), .obj_valid_o(ov), .obj_o(obj),
    .data_clear_o(clr), .ctrl_update_o(cu), .acq_free_o(acq), .trigger_subtract_o(sub), .frame_words_o(frm),
    .window_width_o(wwid), .window_offset_o(woff), .search_margin_o(srch), .reject_margin_o(rej),
    .edge_mode_o(edg), .edge_lsb_o(lsb), .pair_res_o(pres), .dead_time_o(dead), .max_hits_o(hits),
    .save_req_o(sv), .load_req_o(ld), .boot_custom_o(boot));
  omh_host omh_host_i (.ref_clk_i(ref_clk_i), .handshake_i(hs), .word_wr_o(wr), .word_wdata_o(wdata), .word_rd_o(rd));
  function automatic logic [15:0] cur(input logic [7:0] k);
    case (k)
      8'h10: cur = {4'h0, wwid};
      8'h11: cur = {4'h0, woff};
      8'h12: cur = {4'h0, srch};
      8'h13: cur = {4'h0, rej};
      8'h22: cur = {14'h0000, edg};
      8'h24: cur = {14'h0000, lsb};
      8'h25: cur = pres;
      8'h28: cur = {14'h0000, dead};
      default: cur = hits;
    endcase
  endfunction
  function automatic logic [15:0] msk(input logic [7:0] k);
    case (k)
      8'h10, 8'h11, 8'h12, 8'h13: msk = 16'h0FFF;
      8'h22, 8'h24, 8'h28: msk = 16'h0003;
      default: msk = 16'hFFFF;
    endcase
  endfunction
  function automatic logic lvl(input logic [7:0] k);
    case (k)
      8'h00, 8'h01: lvl = acq;
      8'h14, 8'h15: lvl = sub;
      8'h30, 8'h31: lvl = frm;
      default: lvl = boot;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ask(input logic [7:0] q, input logic [31:0] e);
    expq.push_back(e);
    omh_host_i.put({q, v[7:0]});
    omh_host_i.take();
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Each read word is compared with the oldest noted expectation.
  always @(posedge ref_clk_i) begin
    if (rd === 1'b1 && hs[1] === 1'b1) begin
      chk(16'(expq.size() > 0), 16'h0001);
      if (expq.size() > 0) begin
        note = expq.pop_front();
        chk(rdata & note[31:16], note[15:0]);
      end
    end
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial begin
    seed = 32'h6d9594ba;
    v = $random(seed);
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    big = v[0];
    foreach (sets[k]) begin
      c = sets[k];
      v = $random(seed);
      big = v[24];
      omax = v[24] ? 8'h7F : 8'h3F;
      shadow[c] = v[15:0] & msk(c);
      omh_host_i.put({c, v[23:16]});
      omh_host_i.put(v[15:0]);
      repeat (3) @(negedge ref_clk_i);
      chk(cur(c), shadow[c]);
      chk({8'h00, obj}, {8'h00, (v[23:16] > omax) ? omax : v[23:16]});
    end
    ask(8'h23, {16'h0003, shadow[8'h22]});
    ask(8'h26, {16'hFFFF, shadow[8'h25]});
    ask(8'h29, {16'h0003, shadow[8'h28]});
    ask(8'h34, {16'hFFFF, shadow[8'h33]});
    omh_host_i.put({8'h14, v[7:0]});
    foreach (sets[k]) if (k < 4) expq.push_back({16'h0FFF, shadow[sets[k]]});
    expq.push_back({16'h0001, 16'h0001});
    omh_host_i.put({8'h16, v[7:0]});
    repeat (5) omh_host_i.take();
    repeat (4) @(negedge ref_clk_i);
    chk(16'(expq.size()), 16'h0000);
    foreach (modes[k]) begin
      c = modes[k];
      omh_host_i.put({c, v[7:0]});
      chk({14'h0000, sv, ld}, {14'h0000, c == 8'h06, c == 8'h07});
      repeat (3) @(negedge ref_clk_i);
      if (k < 8) chk({15'h0000, lvl(c)}, {15'h0000, k % 2 == 0});
      if (k == 9) foreach (sets[j]) chk(cur(sets[j]), 16'h0000);
      if (k < 2 || k == 4 || k == 5) ask(k < 2 ? 8'h02 : 8'h32, {16'h0001, 15'h0000, k % 2 == 0});
    end
    // A second reset in mid-run must drop both handshake flags and acq, sub, frm, sv and ld, and come back with only the write permit.
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    chk({9'h000, hs[1:0], acq, sub, frm, sv, ld}, 16'h0000);
    rst_n_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk(hs, 16'h0001);
    finish_test();
  end
endmodule
bind omh_mailbox omh_mailbox_monitor omh_mailbox_monitor_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .word_wr_i(word_wr_i), .word_wdata_i(word_wdata_i), .word_rd_i(word_rd_i), .handshake_o(handshake_o),
  .obj_valid_o(obj_valid_o), .ctrl_update_o(ctrl_update_o), .data_clear_o(data_clear_o),
  .window_width_o(window_width_o));
